// ### rtl/cnm_map_mem.sv
// small memory holding the four pdo mapping words, one set for all configurations
`timescale 1ns/1ps
module cnm_map_mem (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic i_wr,
  input wire logic [1:0] i_waddr,
  input wire logic [31:0] i_wdata,
  input wire logic [1:0] i_raddr,
  output logic [31:0] o_rdata
);
  logic [31:0] mem_ff [0:3];
  logic [31:0] rdata_ff;

  // ************************************************************
  // storage, cleared to zero meaning no free mapping
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_word
      always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          mem_ff[g] <= 32'h0000_0000;
        end else if (i_ce && i_wr && i_waddr == 2'(g)) begin
          mem_ff[g] <= i_wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rdata_ff <= 32'h0000_0000;
    end else if (i_ce) begin
      rdata_ff <= mem_ff[i_raddr];
    end
  end

  assign o_rdata = rdata_ff;
endmodule : cnm_map_mem

// ### rtl/cnm_node_mgmt.sv
// node management, pdo identifiers, default mapping and node guarding
// ************************************************************
// How it works
// - every configuration value has a reset default; no setup needed
// - after reset and initialisation the node is pre-operational
// - id 0 frame, byte0 01H, own node address starts the node
// - node address 00H in a command addresses every node
// - id 0 frame, byte0 80H, own or broadcast returns to pre-op
// - service data stays served while pre-operational
// - pdo mapping is captured and held on entering pre-op
// - transmit pdo ids are 180H..480H plus node address
// - receive pdo ids are 200H..500H plus node address
// - default mapping makes tpdo4, rpdo2 and rpdo4 invalid
// - each i/o configuration 0..6 selects a mapping, 0 and 6 alike, 2 and 3 alike; rpdo3 is pwm
// - free mapping is stored to non-volatile memory on write of 1010H
// - one zero-length boot-up frame after every reset
// - guarding request answered on 700H plus node address, one byte
// - guarding status byte carries a toggle inverted per answer
// - life time is factor times guard time, in 1 ms ticks
// - life time expiry: inputs error, emergency, pre-op if 67FE/1029 zero
// - factor and guard time reset to zero
// ************************************************************
`timescale 1ns/1ps
`include "cnm_params.svh"
module cnm_node_mgmt import cnm_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic [6:0] i_node_id,
  input wire logic [2:0] i_io_cfg,
  input wire logic i_init_done,
  input wire logic i_rx_valid,
  input wire cnm_frame_s i_rx_frame,
  input wire logic i_tx_ready,
  input wire logic [15:0] i_guard_time,
  input wire logic [7:0] i_life_factor,
  input wire logic i_cfg_wr,
  input wire logic i_err_behav_zero,
  input wire logic i_map_wr,
  input wire logic [1:0] i_map_idx,
  input wire logic [31:0] i_map_data,
  input wire logic i_store_req,
  input wire logic [1:0] i_map_raddr,
  input wire logic [3:0] i_tpdo_req,
  output logic o_tx_valid,
  output cnm_frame_s o_tx_frame,
  output logic o_operational,
  output logic o_preop,
  output logic o_sdo_enable,
  output logic [15:0] o_guard_time,
  output logic [7:0] o_life_factor,
  output logic [3:0] o_rpdo_strobe,
  output logic [63:0] o_rpdo_data,
  output cnm_pdo_t o_tpdo_valid,
  output cnm_pdo_t o_rpdo_valid,
  output logic o_inputs_error,
  output logic o_nvm_store,
  output logic [31:0] o_map_rdata
);

  // ************************************************************
  // decoding
  // ************************************************************
  function automatic logic [10:0] node_cob(input logic [10:0] base,
                                           input logic [6:0] node);
    node_cob = base + {4'h0, node};
  endfunction : node_cob

  function automatic logic [10:0] rx_base(input logic [1:0] n);
    case (n)
      2'd0: rx_base = `CNM_ID_RPDO1;
      2'd1: rx_base = `CNM_ID_RPDO2;
      2'd2: rx_base = `CNM_ID_RPDO3;
      default: rx_base = `CNM_ID_RPDO4;
    endcase
  endfunction : rx_base

  function automatic logic [10:0] tx_base(input logic [1:0] n);
    case (n)
      2'd0: tx_base = `CNM_ID_TPDO1;
      2'd1: tx_base = `CNM_ID_TPDO2;
      2'd2: tx_base = `CNM_ID_TPDO3;
      default: tx_base = `CNM_ID_TPDO4;
    endcase
  endfunction : tx_base

  cnm_state_e state_ff, nxt_state;
  logic boot_pend_ff, emcy_pend_ff, guard_pend_ff, toggle_ff;
  logic [3:0] tpdo_pend_ff;
  logic tx_valid_ff;
  cnm_frame_s tx_frame_ff;
  logic [15:0] guard_ff;
  logic [7:0] factor_ff;
  logic [23:0] life_cnt_ff;
  logic [15:0] tick_cnt_ff;
  logic inerr_ff, store_ff;
  logic [3:0] rpdo_stb_ff;
  logic [63:0] rpdo_data_ff;
  logic [3:0] tval_ff, rval_ff;

  wire logic is_oper = (state_ff == CNM_OPER);
  wire logic is_preop = (state_ff == CNM_PREOP);
  wire logic nmt_hit = i_rx_valid && !i_rx_frame.rtr &&
    i_rx_frame.id == `CNM_ID_NMT && i_rx_frame.dlc == 4'd2 &&
    (i_rx_frame.data[14:8] == i_node_id ||
     i_rx_frame.data[14:8] == `CNM_NODE_ALL) &&
    i_rx_frame.data[15] == 1'b0;
  wire logic cmd_start = nmt_hit &&
    i_rx_frame.data[7:0] == `CNM_CMD_START;
  wire logic cmd_preop = nmt_hit &&
    i_rx_frame.data[7:0] == `CNM_CMD_PREOP;
  wire logic guard_req = i_rx_valid && i_rx_frame.rtr && i_rx_frame.id ==
    node_cob(`CNM_ID_GUARD, i_node_id);
  wire logic [23:0] life_time = 24'(guard_ff) * 24'(factor_ff);
  wire logic life_on = (life_time != 24'h00_0000) && !is_operational_init();
  wire logic tick = (tick_cnt_ff == 16'(`CNM_TICK_CYC - 1));
  wire logic life_exp = life_on && tick && !guard_req &&
    (life_cnt_ff == life_time - 24'h00_0001);

  function automatic logic is_operational_init();
    is_operational_init = (state_ff == CNM_INIT);
  endfunction : is_operational_init

  // ************************************************************
  // default mapping per i/o configuration
  // ************************************************************
  logic [3:0] dflt_tval, dflt_rval;
  always_comb begin
    dflt_tval = 4'b0001;
    dflt_rval = 4'b0101;
    case (i_io_cfg)
      3'd0: dflt_tval = 4'b0011;
      3'd1: dflt_tval = 4'b0111;
      3'd2: dflt_tval = 4'b0001;
      3'd3: dflt_tval = 4'b0001;
      3'd4: begin
        dflt_tval = 4'b0111;
        dflt_rval = 4'b0100;
      end
      3'd5: dflt_rval = 4'b0100;
      3'd6: dflt_tval = 4'b0011;
      default: dflt_tval = 4'b0001;
    endcase
  end

  // ************************************************************
  // boot state machine
  // ************************************************************
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      CNM_INIT: if (i_init_done) nxt_state = CNM_PREOP;
      CNM_PREOP: if (cmd_start) nxt_state = CNM_OPER;
      CNM_OPER: begin
        if (cmd_preop) nxt_state = CNM_PREOP;
        else if (life_exp && i_err_behav_zero) nxt_state = CNM_PREOP;
      end
      default: nxt_state = CNM_INIT;
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_ff <= CNM_INIT;
    end else if (i_ce) begin
      state_ff <= nxt_state;
    end
  end

  // ************************************************************
  // configuration: guard and factor written outside init, mapping held while pre-operational
  // ************************************************************
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      guard_ff <= `CNM_GUARD_RST;
      factor_ff <= `CNM_FACTOR_RST;
      tval_ff <= 4'h0;
      rval_ff <= 4'h0;
      store_ff <= 1'b0;
    end else if (i_ce) begin
      if (i_cfg_wr && !is_operational_init()) begin
        guard_ff <= i_guard_time;
        factor_ff <= i_life_factor;
      end
      // mapping snapshot frozen in pre-op, follows the defaults in init and operational
      if (is_oper || is_operational_init()) begin
        tval_ff <= dflt_tval;
        rval_ff <= dflt_rval;
      end
      store_ff <= i_store_req;
    end
  end

  // ************************************************************
  // life time supervision on the 1 ms tick
  // ************************************************************
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tick_cnt_ff <= 16'h0000;
      life_cnt_ff <= 24'h00_0000;
      inerr_ff <= 1'b0;
    end else if (i_ce) begin
      tick_cnt_ff <= (tick || guard_req || !life_on) ? 16'h0000 :
                     tick_cnt_ff + 16'h0001;
      if (guard_req || !life_on) begin
        life_cnt_ff <= 24'h00_0000;
      end else if (tick && !life_exp) begin
        life_cnt_ff <= life_cnt_ff + 24'h00_0001;
      end else if (life_exp) begin
        life_cnt_ff <= 24'h00_0000;
      end
      if (life_exp) inerr_ff <= 1'b1;
      else if (cmd_start) inerr_ff <= 1'b0;
    end
  end

  // ************************************************************
  // receive process data and transmit requests
  // ************************************************************
  logic [3:0] rx_hit;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_rx
      assign rx_hit[g] = i_rx_valid && !i_rx_frame.rtr && is_oper &&
        rval_ff[g] &&
        i_rx_frame.id == node_cob(rx_base(2'(g)), i_node_id);
    end
  endgenerate

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rpdo_stb_ff <= 4'h0;
      rpdo_data_ff <= 64'h0;
    end else if (i_ce) begin
      rpdo_stb_ff <= rx_hit;
      if (|rx_hit) rpdo_data_ff <= i_rx_frame.data;
    end
  end

  // ************************************************************
  // transmit arbiter: boot-up, guarding, emergency, then pdos
  // ************************************************************
  wire logic tx_free = !tx_valid_ff || i_tx_ready;
  logic [1:0] tp_sel;
  always_comb begin
    tp_sel = 2'd3;
    if (tpdo_pend_ff[2]) tp_sel = 2'd2;
    if (tpdo_pend_ff[1]) tp_sel = 2'd1;
    if (tpdo_pend_ff[0]) tp_sel = 2'd0;
  end
  wire logic go_boot = tx_free && boot_pend_ff && !is_operational_init();
  wire logic go_guard = tx_free && !go_boot && guard_pend_ff;
  wire logic go_emcy = tx_free && !go_boot && !go_guard && emcy_pend_ff;
  wire logic go_tpdo = tx_free && !go_boot && !go_guard && !go_emcy &&
    is_oper && |tpdo_pend_ff;
  wire logic [6:0] st_code = is_oper ? `CNM_ST_OPER : `CNM_ST_PREOP;

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      boot_pend_ff <= 1'b1;
      guard_pend_ff <= 1'b0;
      emcy_pend_ff <= 1'b0;
      tpdo_pend_ff <= 4'h0;
      toggle_ff <= 1'b0;
      tx_valid_ff <= 1'b0;
      tx_frame_ff <= '0;
    end else if (i_ce) begin
      if (go_boot) boot_pend_ff <= 1'b0;
      guard_pend_ff <= guard_req || (guard_pend_ff && !go_guard);
      emcy_pend_ff <= life_exp || (emcy_pend_ff && !go_emcy);
      tpdo_pend_ff <= (tpdo_pend_ff & ~((go_tpdo ? 4'h1 : 4'h0) << tp_sel))
        | (i_tpdo_req & tval_ff & {4{is_oper}});
      if (tx_free) tx_valid_ff <= go_boot | go_guard | go_emcy | go_tpdo;
      if (go_boot) begin
        tx_frame_ff <= '{id: node_cob(`CNM_ID_GUARD, i_node_id),
                         rtr: 1'b0, dlc: 4'd0, data: 64'h0};
      end else if (go_guard) begin
        tx_frame_ff <= '{id: node_cob(`CNM_ID_GUARD, i_node_id),
                         rtr: 1'b0, dlc: 4'd1,
                         data: {56'h0, toggle_ff, st_code}};
        toggle_ff <= ~toggle_ff;
      end else if (go_emcy) begin
        tx_frame_ff <= '{id: node_cob(`CNM_ID_EMCY, i_node_id),
                         rtr: 1'b0, dlc: 4'd8, data: 64'h0};
      end else if (go_tpdo) begin
        tx_frame_ff <= '{id: node_cob(tx_base(tp_sel), i_node_id),
                         rtr: 1'b0, dlc: 4'd8, data: 64'h0};
      end
    end
  end

  // ************************************************************
  // free mapping memory
  // ************************************************************
  cnm_map_mem u_map (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_wr(i_map_wr),
    .i_waddr(i_map_idx),
    .i_wdata(i_map_data),
    .i_raddr(i_map_raddr),
    .o_rdata(o_map_rdata)
  );

  logic oper_ff, preop_ff, sdo_ff;
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      oper_ff <= 1'b0;
      preop_ff <= 1'b0;
      sdo_ff <= 1'b0;
    end else if (i_ce) begin
      oper_ff <= (nxt_state == CNM_OPER);
      preop_ff <= (nxt_state == CNM_PREOP);
      sdo_ff <= (nxt_state == CNM_OPER) || (nxt_state == CNM_PREOP);
    end
  end

  assign o_tx_valid = tx_valid_ff;
  assign o_tx_frame = tx_frame_ff;
  assign o_operational = oper_ff;
  assign o_preop = preop_ff;
  assign o_sdo_enable = sdo_ff;
  assign o_guard_time = guard_ff;
  assign o_life_factor = factor_ff;
  assign o_rpdo_strobe = rpdo_stb_ff;
  assign o_rpdo_data = rpdo_data_ff;
  assign o_tpdo_valid = tval_ff;
  assign o_rpdo_valid = rval_ff;
  assign o_inputs_error = inerr_ff;
  assign o_nvm_store = store_ff;
endmodule : cnm_node_mgmt

// ### rtl/cnm_params.svh
// constants for the node management and guarding block
`ifndef CNM_PARAMS_SVH
`define CNM_PARAMS_SVH
`define CNM_ID_NMT 11'h000
`define CNM_CMD_START 8'h01
`define CNM_CMD_PREOP 8'h80
`define CNM_NODE_ALL 7'h00
`define CNM_ID_TPDO1 11'h180
`define CNM_ID_TPDO2 11'h280
`define CNM_ID_TPDO3 11'h380
`define CNM_ID_TPDO4 11'h480
`define CNM_ID_RPDO1 11'h200
`define CNM_ID_RPDO2 11'h300
`define CNM_ID_RPDO3 11'h400
`define CNM_ID_RPDO4 11'h500
`define CNM_ID_GUARD 11'h700
`define CNM_ID_EMCY 11'h080
`define CNM_ST_PREOP 7'h7F
`define CNM_ST_OPER 7'h05
`define CNM_ST_BOOT 7'h00
`define CNM_GUARD_RST 16'h0000
`define CNM_FACTOR_RST 8'h00
`define CNM_TICK_NS 1000000
`define CNM_CLK_NS 40
`define CNM_TICK_CYC (`CNM_TICK_NS / `CNM_CLK_NS)
`define CNM_CFG_W 3
`endif

// ### rtl/cnm_pkg.sv
// types shared by the node management block
package cnm_pkg;
  typedef struct packed {
    logic [10:0] id;
    logic rtr;
    logic [3:0] dlc;
    logic [63:0] data;
  } cnm_frame_s;

  typedef enum logic [2:0] {
    CNM_INIT = 3'b001,
    CNM_PREOP = 3'b010,
    CNM_OPER = 3'b100
  } cnm_state_e;

  typedef logic [3:0] cnm_pdo_t;
endpackage : cnm_pkg

// ### testbench/cnm_master_model.sv
// network master model: sends frames to the node, paces its replies
`timescale 1ns/1ps
module cnm_master_model import cnm_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_slow,
  output logic o_rx_valid,
  output cnm_frame_s o_rx_frame,
  output logic o_tx_ready
);
  logic [1:0] cnt_ff = 2'h0;
  initial begin
    o_rx_valid = 1'b0;
    o_rx_frame = '0;
  end
  always @(posedge i_sys_clk) begin
    cnt_ff <= cnt_ff + 2'h1;
  end
  // slow mode takes a reply only every fourth cycle
  assign o_tx_ready = !i_slow || cnt_ff == 2'h3;
  // one frame per call; released lines show the inverse afterwards
  task automatic send(input cnm_frame_s f);
    @(posedge i_sys_clk);
    o_rx_valid <= 1'b1;
    o_rx_frame <= f;
    @(posedge i_sys_clk);
    o_rx_valid <= 1'b0;
    o_rx_frame <= ~f;
  endtask : send
endmodule : cnm_master_model

// ### testbench/cnm_node_mgmt_monitor.sv
// port assertions for the node management block
`timescale 1ns/1ps
module cnm_node_mgmt_monitor import cnm_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic [6:0] i_node_id,
  input wire logic i_rx_valid,
  input wire cnm_frame_s i_rx_frame,
  input wire logic i_tx_ready,
  input wire logic i_store_req,
  input wire logic o_tx_valid,
  input wire cnm_frame_s o_tx_frame,
  input wire logic o_operational,
  input wire logic o_preop,
  input wire logic o_sdo_enable,
  input wire logic [15:0] o_guard_time,
  input wire logic [7:0] o_life_factor,
  input wire logic o_inputs_error,
  input wire logic o_nvm_store
);
  // ****************************************
  // helper logic
  // ****************************************
  logic tog_ff;
  logic seen_ff;
  wire logic [10:0] own_g = 11'h700 + 11'(i_node_id);
  wire logic rx_ok = i_ce && i_rx_valid && o_sdo_enable;
  wire logic [7:0] nd = i_rx_frame.data[15:8];
  wire logic nmt = rx_ok && !i_rx_frame.rtr && i_rx_frame.id == 11'h000
    && i_rx_frame.dlc == 4'h2 && (nd == {1'b0, i_node_id} || nd == 8'h00);
  wire logic g_take = i_ce && o_tx_valid && i_tx_ready
    && o_tx_frame.id == own_g && o_tx_frame.dlc == 4'h1;
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tog_ff <= 1'b0;
      seen_ff <= 1'b0;
    end else if (g_take) begin
      tog_ff <= o_tx_frame.data[7];
      seen_ff <= 1'b1;
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_guard_req;
    rx_ok && i_rx_frame.rtr && i_rx_frame.id == own_g;
  endsequence
  sequence s_guard_tx;
    ##[1:40] (o_tx_valid && o_tx_frame.id == own_g && o_tx_frame.dlc == 4'h1);
  endsequence
  property p_guard; s_guard_req |-> s_guard_tx; endproperty
  property p_start; nmt && i_rx_frame.data[7:0] == 8'h01 |=> o_operational;
  endproperty
  property p_stop; nmt && i_rx_frame.data[7:0] == 8'h80 |=> o_preop;
  endproperty
  property p_sdo; o_preop || o_operational |-> o_sdo_enable; endproperty
  property p_hold;
    o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_frame);
  endproperty
  property p_toggle; g_take && seen_ff |-> o_tx_frame.data[7] != tog_ff;
  endproperty
  property p_status;
    g_take |-> o_tx_frame.data[6:0] == (o_operational ? 7'h05 : 7'h7F);
  endproperty
  property p_boot; $rose(o_sdo_enable) |-> ##[0:3]
    (o_tx_valid && o_tx_frame.id == own_g && o_tx_frame.dlc == 4'h0);
  endproperty
  property p_emcy; $rose(o_inputs_error) |-> ##[0:40] (o_tx_valid
    && o_tx_frame.id == 11'h080 + 11'(i_node_id) && o_tx_frame.dlc == 4'h8);
  endproperty
  property p_life; $rose(o_inputs_error) |->
    o_life_factor != 8'h00 && o_guard_time != 16'h0000;
  endproperty
  property p_store; i_ce && i_store_req |=> o_nvm_store; endproperty
  a_guard: assert property (p_guard) else $error("no guard reply");
  a_start: assert property (p_start) else $error("start ignored");
  a_stop: assert property (p_stop) else $error("stop ignored");
  a_sdo: assert property (p_sdo) else $error("service data off");
  a_hold: assert property (p_hold) else $error("tx frame dropped");
  a_toggle: assert property (p_toggle) else $error("toggle stuck");
  a_status: assert property (p_status) else $error("bad status");
  a_boot: assert property (p_boot) else $error("no boot frame");
  a_emcy: assert property (p_emcy) else $error("no emergency");
  a_life: assert property (p_life) else $error("zero life time");
  a_store: assert property (p_store) else $error("no store");
endmodule : cnm_node_mgmt_monitor
bind cnm_node_mgmt cnm_node_mgmt_monitor cnm_node_mgmt_monitor_inst (.*);

// ### testbench/cnm_node_mgmt_test.sv
// self-checking bench for the node management block
`timescale 1ns/1ps
`include "cnm_params.svh"
module cnm_node_mgmt_test import cnm_pkg::*;;
  logic i_sys_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [6:0] node;
  logic [2:0] io_cfg = 3'h1;
  logic init_done = 1'b0, cfg_wr = 1'b0, ebz = 1'b0, slow = 1'b0;
  logic map_wr = 1'b0, store = 1'b0, tog = 1'b0, ce = 1'b1;
  logic [15:0] guard_t = 16'h0000;
  logic [7:0] life_f = 8'h00;
  logic [31:0] rs = 32'h10;
  logic [31:0] map_d = 32'h0, map_q;
  logic [63:0] rd_exp = 64'h0, rdat;
  logic [3:0] tpdo_req = 4'h0, rstb, tpv, rpv;
  logic rx_valid, tx_ready, tx_valid, oper, preop, in_err;
  logic [15:0] o_gt;
  logic [7:0] o_lf;
  cnm_frame_s rx_frame, tx_frame;
  cnm_frame_s exp_q[$];
  bit full_q[$];
  int bad_count = 0, compares = 0, n;
  logic [3:0] tv [7] = '{4'h3, 4'h7, 4'h1, 4'h1, 4'h7, 4'h1, 4'h3};
  logic [3:0] rv [7] = '{4'h5, 4'h5, 4'h5, 4'h5, 4'h4, 4'h4, 4'h5};
  always #20 i_sys_clk = ~i_sys_clk;
  cnm_master_model cnm_master_model_inst (.i_sys_clk(i_sys_clk),
    .i_slow(slow), .o_rx_valid(rx_valid), .o_rx_frame(rx_frame),
    .o_tx_ready(tx_ready));
  cnm_node_mgmt cnm_node_mgmt_inst (.i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst), .i_ce(ce), .i_node_id(node), .i_io_cfg(io_cfg),
    .i_init_done(init_done), .i_rx_valid(rx_valid), .i_rx_frame(rx_frame),
    .i_tx_ready(tx_ready), .i_guard_time(guard_t), .i_life_factor(life_f),
    .i_cfg_wr(cfg_wr), .i_err_behav_zero(ebz), .i_map_wr(map_wr),
    .i_map_idx(2'h1), .i_map_data(map_d), .i_store_req(store),
    .i_map_raddr(2'h1), .i_tpdo_req(tpdo_req), .o_tx_valid(tx_valid),
    .o_tx_frame(tx_frame), .o_operational(oper), .o_preop(preop),
    .o_sdo_enable(), .o_guard_time(o_gt), .o_life_factor(o_lf),
    .o_rpdo_strobe(rstb), .o_rpdo_data(rdat), .o_tpdo_valid(tpv),
    .o_rpdo_valid(rpv), .o_inputs_error(in_err), .o_nvm_store(),
    .o_map_rdata(map_q));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic cyc(input int k);
    repeat (k) @(posedge i_sys_clk);
  endtask : cyc
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_frame(input cnm_frame_s got, exp, input bit full);
    compares++;
    if (got.id !== exp.id || (full && got[68:0] !== exp[68:0])) begin
      bad_count++;
      $display("[ERR] %0t frame %0h expected %0h", $time, got, exp);
    end
  endtask : chk_frame
  task automatic expect_tx(input logic [10:0] id, input logic [3:0] dlc,
                           input logic [63:0] d, input bit full);
    exp_q.push_back({id, 1'b0, dlc, d});
    full_q.push_back(full);
  endtask : expect_tx
  task automatic nmt(input logic [7:0] cmd, input logic [6:0] nd);
    cnm_master_model_inst.send({11'h000, 1'b0, 4'h2, 48'h0, 1'b0, nd, cmd});
    cyc(3);
  endtask : nmt
  task automatic guard(input logic [6:0] st);
    expect_tx(11'h700 + 11'(node), 4'h1, {56'h0, tog, st}, 1'b1);
    tog = ~tog;
    cnm_master_model_inst.send({11'h700 + 11'(node), 1'b1, 4'h0,
      64'h0});
  endtask : guard
  task automatic drain;
    n = 0;
    while (exp_q.size() != 0 && n < 300) begin
      cyc(1);
      n++;
    end
    chk(32'(exp_q.size()), 32'h0);
  endtask : drain
  task automatic rpdo_all(input logic [3:0] exp);
    logic [3:0] acc;
    acc = 4'h0;
    fork
      for (int k = 0; k < 4; k++) begin
        rs = xs(rs);
        if (exp[k]) rd_exp = {rs, ~rs};
        cnm_master_model_inst.send({11'h200 + 11'(k) * 11'h100 + 11'(node),
          1'b0, 4'h8, rs, ~rs});
      end
      repeat (14) begin
        @(posedge i_sys_clk);
        acc |= rstb;
      end
    join
    chk(32'(acc), 32'(exp));
    chk(rdat[63:32], rd_exp[63:32]);
    chk(rdat[31:0], rd_exp[31:0]);
  endtask : rpdo_all
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run
  always @(posedge i_sys_clk) begin
    if (tx_valid && tx_ready) begin
      if (exp_q.size() == 0) begin
        bad_count++;
        $display("[ERR] %0t unexpected frame %0h", $time, tx_frame.id);
      end else begin
        chk_frame(tx_frame, exp_q.pop_front(), full_q.pop_front());
      end
    end
  end
  initial begin
    cyc(90000);
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run();
  end
  initial begin
    rs = xs(rs);
    node = 7'(rs % 127) + 7'h01;
    cyc(6);
    i_sys_rst <= 1'b0;
    expect_tx(11'h700 + 11'(node), 4'h0, 64'h0, 1'b1);
    cyc(3);
    init_done <= 1'b1;
    cyc(4);
    chk(32'(preop), 32'h1);
    chk({o_gt, o_lf, 8'h0}, 32'h0);
    drain();
    $display("boot done");
    slow <= 1'b1;
    guard(7'h7F);
    cyc(12);
    guard(7'h7F);
    drain();
    slow <= 1'b0;
    $display("guarding done");
    nmt(8'h01, 7'(node % 127) + 7'h01);
    chk(32'(oper), 32'h0);
    nmt(8'h01, 7'h00);
    chk(32'(oper), 32'h1);
    ce <= 1'b0;
    nmt(8'h80, 7'h00);
    ce <= 1'b1;
    chk(32'(oper), 32'h1);
    guard(7'h05);
    drain();
    $display("start done");
    for (int c = 0; c < 7; c++) begin
      io_cfg <= 3'(c);
      cyc(4);
      chk(32'(tpv), 32'(tv[c]));
      chk(32'(rpv), 32'(rv[c]));
    end
    io_cfg <= 3'h1;
    cyc(4);
    expect_tx(11'h180 + 11'(node), 4'h0, 64'h0, 1'b0);
    expect_tx(11'h280 + 11'(node), 4'h0, 64'h0, 1'b0);
    expect_tx(11'h380 + 11'(node), 4'h0, 64'h0, 1'b0);
    tpdo_req <= 4'hF;
    cyc(1);
    tpdo_req <= 4'h0;
    drain();
    rpdo_all(4'h5);
    rs = xs(rs);
    map_d <= rs;
    map_wr <= 1'b1;
    cyc(1);
    map_wr <= 1'b0;
    store <= 1'b1;
    cyc(1);
    store <= 1'b0;
    cyc(3);
    chk(map_q, rs);
    $display("process data done");
    nmt(8'h80, node);
    chk({30'h0, oper, preop}, 32'h1);
    rpdo_all(4'h0);
    tpdo_req <= 4'hF;
    cyc(1);
    tpdo_req <= 4'h0;
    guard(7'h7F);
    drain();
    $display("stop done");
    guard_t <= 16'h0001;
    life_f <= 8'h02;
    ebz <= 1'b1;
    cfg_wr <= 1'b1;
    cyc(1);
    cfg_wr <= 1'b0;
    nmt(8'h01, node);
    chk({o_gt, o_lf, 8'h0}, 32'h00010200);
    guard(7'h05);
    drain();
    expect_tx(11'h080 + 11'(node), 4'h8, 64'h0, 1'b1);
    n = 0;
    while (!in_err && n < 60000) begin
      cyc(1);
      n++;
    end
    chk(32'(n > `CNM_TICK_CYC && n < 2 * `CNM_TICK_CYC + 300), 32'h1);
    cyc(2);
    chk({30'h0, oper, preop}, 32'h1);
    drain();
    $display("life time done");
    complete_run();
  end
endmodule : cnm_node_mgmt_test
